/* logic/wdct_pkg.sv */
// Package with register map, reset values and carrier types of the watchdog countdown timer.
package wdct_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] WDCT_OFF_COUNT    = 8'h00;
  localparam logic [7:0] WDCT_OFF_RELOAD   = 8'h04;
  localparam logic [7:0] WDCT_OFF_RESTART  = 8'h08;
  localparam logic [7:0] WDCT_OFF_CONTROL  = 8'h0C;
  localparam logic [7:0] WDCT_OFF_STATUS   = 8'h10;
  localparam logic [7:0] WDCT_OFF_CLEAR    = 8'h14;
  localparam logic [7:0] WDCT_OFF_PLEN     = 8'h18;
  localparam logic [7:0] WDCT_OFF_REVISION = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned WDCT_BIT_ENABLE  = 0;
  localparam int unsigned WDCT_BIT_RST_EN  = 1;
  localparam int unsigned WDCT_BIT_IRQ_EN  = 2;
  localparam int unsigned WDCT_BIT_EXT_EN  = 3;
  localparam int unsigned WDCT_BIT_CLK_SEL = 4;
  localparam int unsigned WDCT_BIT_FLAG    = 0;

  localparam logic [31:0] WDCT_RST_COUNT   = 32'h03EF1480;
  localparam logic [31:0] WDCT_RST_RELOAD  = 32'h03EF1480;
  localparam logic [4:0]  WDCT_RST_CONTROL = 5'h00;
  localparam logic [7:0]  WDCT_RST_PLEN    = 8'hFF;
  localparam logic [15:0] WDCT_RESTART_KEY = 16'h5AB9;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } wdct_req_s;

  typedef struct packed {
    logic ext_en;
    logic irq_en;
    logic rst_en;
  } wdct_pulse_s;

endpackage

/* logic/wdct_top.sv */
// Watchdog countdown timer with reload key, sticky zero flag and stretched output pulses.
//
// How it works
// RULE1 - The counter steps down once per count tick while the enable bit is set.
// RULE2 - With the enable bit clear the counter holds its value; a key write to the restart register still reloads it.
// RULE3 - Control bit 4 picks the count tick: bus clock when 0, external count clock when 1.
// RULE4 - After reset both the count and reload registers hold 0x3EF1480.
// RULE5 - Writing key 0x5AB9 to the restart register copies the reload value into the counter.
// RULE6 - The restart register returns to zero once its write cycle has finished.
// RULE7 - Reaching zero sets a sticky, read-only status flag at bit 0.
// RULE8 - Any write to the clear register, of 1 or of 0, clears the status flag.
// RULE9 - On reaching zero with control bit 1 set, the system reset pulse is driven.
// RULE10 - On reaching zero with control bit 2 set, the system interrupt pulse is driven.
// RULE11 - On reaching zero with control bit 3 set, the external device pulse is driven.
// RULE12 - The pulses last the pulse length register value plus one cycles, 256 by default.
// RULE13 - The count register is read-only and bus writes leave it unchanged.
// RULE14 - Software must write the key often enough that the counter never reaches zero.
// RULE15 - A read-only revision register at 0x1C returns a fixed code.
// RULE16 - Non-key restart writes do nothing, and each arrival at zero fires the pulses once; an arrival while a pulse is still active starts no new pulse.
`timescale 1ns/1ps

module wdct_top
  import wdct_pkg::*;
#(
  parameter logic [31:0] REVISION = 32'h00010000  // Arbitrary revision code.
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        reg_sel,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        external_count_clock,
  output logic             system_reset_pulse,
  output logic             system_irq_pulse,
  output logic             external_device_pulse,
  output logic             status_pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WDCT_IDLE  = 2'b00,
    WDCT_PULSE = 2'b01
  } wdct_state_e;

  typedef struct packed {
    wdct_state_e state;
    logic [31:0] count;
    logic [31:0] reload;
    logic [15:0] restart_key;
    logic [4:0]  control;
    logic        flag;
    logic [7:0]  plen;
    logic [7:0]  pcnt;
    wdct_pulse_s pen;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
    logic [31:0] rdata;
  } wdct_state_s;

  wdct_state_s s_q;
  wdct_state_s s_d;
  wdct_req_s   req;
  logic        tick;
  logic        reach;
  logic        wr;

  assign req = '{sel: reg_sel, write: reg_write, addr: reg_addr, wdata: reg_wdata};
  assign wr  = req.sel && req.write;

  // ----------------------------------------------------------------
  // Count tick and zero detection
  // ----------------------------------------------------------------
  // RULE3 clock select
  // The external clock is treated as a slow level and counted on its rising edge after
  // two flops; it must stay below half the bus clock rate or edges are lost.
  assign tick = s_q.control[WDCT_BIT_CLK_SEL] ? (s_q.ext_s2 && !s_q.ext_s3) : 1'b1;
  // RULE16 once per reach
  assign reach = s_q.control[WDCT_BIT_ENABLE] && tick && (s_q.count == 32'h00000001);

  always_comb begin
    s_d        = s_q;
    s_d.ext_s1 = external_count_clock;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;
    // RULE6 key auto clear
    s_d.restart_key = 16'h0000;
    // RULE1 count down
    if (s_q.control[WDCT_BIT_ENABLE] && tick && (s_q.count != 32'h00000000)) begin
      s_d.count = s_q.count - 32'h00000001;
    end
    // RULE2 hold when disabled is the default path above.
    if (wr) begin
      case (req.addr)
        WDCT_OFF_RELOAD: begin
          s_d.reload = req.wdata;
        end
        WDCT_OFF_RESTART: begin
          // RULE5 key reload
          s_d.restart_key = req.wdata[15:0];
          if (req.wdata[15:0] == WDCT_RESTART_KEY) begin
            s_d.count = s_q.reload;
          end
        end
        WDCT_OFF_CONTROL: begin
          s_d.control = req.wdata[4:0];
        end
        WDCT_OFF_PLEN: begin
          s_d.plen = req.wdata[7:0];
        end
        // RULE13 count read only
        default: begin
        end
      endcase
    end
    // RULE8 clear flag
    if (wr && req.addr == WDCT_OFF_CLEAR) begin
      s_d.flag = 1'b0;
    end
    // RULE7 sticky flag, set wins over clear
    if (reach) begin
      s_d.flag = 1'b1;
    end
    // RULE12 pulse stretcher
    case (s_q.state)
      WDCT_IDLE: begin
        if (reach) begin
          s_d.state = WDCT_PULSE;
          s_d.pcnt  = s_q.plen;
          s_d.pen   = '{ext_en: s_q.control[WDCT_BIT_EXT_EN],
                        irq_en: s_q.control[WDCT_BIT_IRQ_EN],
                        rst_en: s_q.control[WDCT_BIT_RST_EN]};
        end
      end
      WDCT_PULSE: begin
        if (s_q.pcnt == 8'h00) begin
          s_d.state = WDCT_IDLE;
          s_d.pen   = '0;
        end else begin
          s_d.pcnt = s_q.pcnt - 8'h01;
        end
      end
      default: begin
        s_d.state = WDCT_IDLE;
      end
    endcase
    // Registered read data, valid one cycle after the read request.
    s_d.rdata = 32'h00000000;
    if (req.sel && !req.write) begin
      case (req.addr)
        WDCT_OFF_COUNT:    s_d.rdata = s_q.count;
        WDCT_OFF_RELOAD:   s_d.rdata = s_q.reload;
        WDCT_OFF_CONTROL:  s_d.rdata = {27'h0000000, s_q.control};
        WDCT_OFF_STATUS:   s_d.rdata = {31'h00000000, s_q.flag};
        WDCT_OFF_PLEN:     s_d.rdata = {24'h000000, s_q.plen};
        // RULE15 revision
        WDCT_OFF_REVISION: s_d.rdata = REVISION;
        default:           s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // RULE4 reset values
      s_q.state       <= WDCT_IDLE;
      s_q.count       <= WDCT_RST_COUNT;
      s_q.reload      <= WDCT_RST_RELOAD;
      // RULE6 key auto clear
      s_q.restart_key <= 16'h0000;
      s_q.control     <= WDCT_RST_CONTROL;
      s_q.flag        <= 1'b0;
      s_q.plen        <= WDCT_RST_PLEN;
      s_q.pcnt        <= 8'h00;
      s_q.pen         <= '0;
      s_q.ext_s1      <= 1'b0;
      s_q.ext_s2      <= 1'b0;
      s_q.ext_s3      <= 1'b0;
      s_q.rdata       <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic active;
  assign active = (s_q.state == WDCT_PULSE);
  assign reg_rdata = s_q.rdata;
  // RULE9 reset pulse
  assign system_reset_pulse    = active && s_q.pen.rst_en;
  // RULE10 irq pulse
  assign system_irq_pulse      = active && s_q.pen.irq_en;
  // RULE11 external pulse
  assign external_device_pulse = active && s_q.pen.ext_en;
  assign status_pulse          = active;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [8:0] plen_cnt;
  always_ff @(posedge clk) begin
    if (sys_rst || !active) begin
      plen_cnt <= 9'h000;
    end else begin
      plen_cnt <= plen_cnt + 9'h001;
    end
  end

  // The length is judged against the value latched when the pulse starts, so that a write
  // to the pulse length register during a pulse does not trip the check.
  logic [7:0] plen_seen;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      plen_seen <= WDCT_RST_PLEN;
    end else if (reach && !active) begin
      plen_seen <= s_q.plen;
    end
  end

  hold_disabled_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    !s_q.control[WDCT_BIT_ENABLE] && !(wr && req.addr == WDCT_OFF_RESTART)
      |=> s_q.count == $past(s_q.count)) else $error("count moved while disabled");
  count_down_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    s_q.control[WDCT_BIT_ENABLE] && !s_q.control[WDCT_BIT_CLK_SEL] && s_q.count != 0
      && !wr |=> s_q.count == $past(s_q.count) - 32'h00000001)
    else $error("count did not step down");
  key_reload_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    wr && req.addr == WDCT_OFF_RESTART && req.wdata[15:0] == WDCT_RESTART_KEY
      |=> s_q.count == $past(s_q.reload)) else $error("key did not reload");
  bad_key_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    wr && req.addr == WDCT_OFF_RESTART && req.wdata[15:0] != WDCT_RESTART_KEY
      && !s_q.control[WDCT_BIT_ENABLE] |=> $stable(s_q.count))
    else $error("bad key changed count");
  key_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    s_q.restart_key != 16'h0000 && !(wr && req.addr == WDCT_OFF_RESTART)
      |=> s_q.restart_key == 16'h0000)
    else $error("restart key not cleared");
  flag_set_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    reach |=> s_q.flag ##1 (s_q.flag || $past(wr && req.addr == WDCT_OFF_CLEAR)))
    else $error("flag not set on zero");
  flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    wr && req.addr == WDCT_OFF_CLEAR && !reach |=> !s_q.flag)
    else $error("flag not cleared");
  reset_pulse_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
    reach && !active && s_q.control[WDCT_BIT_RST_EN] |=> system_reset_pulse)
    else $error("reset pulse missing");
  irq_pulse_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
    reach && !active && s_q.control[WDCT_BIT_IRQ_EN] |=> system_irq_pulse)
    else $error("irq pulse missing");
  ext_pulse_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
    reach && !active && s_q.control[WDCT_BIT_EXT_EN] |=> external_device_pulse)
    else $error("external pulse missing");
  pulse_len_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    $fell(active) |-> plen_cnt == {1'b0, plen_seen} + 9'h001)
    else $error("pulse length wrong");

  // ----------------------------------------------------------------
  // Register access checks
  // ----------------------------------------------------------------
  reset_state_a: assert property (@(posedge clk) // RULE4
    $fell(sys_rst) |-> s_q.count == WDCT_RST_COUNT && s_q.reload == WDCT_RST_RELOAD
      && s_q.plen == WDCT_RST_PLEN && s_q.control == WDCT_RST_CONTROL)
    else $error("reset values wrong");
  reload_write_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    wr && req.addr == WDCT_OFF_RELOAD |=> s_q.reload == $past(req.wdata))
    else $error("reload write lost");
  control_write_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    wr && req.addr == WDCT_OFF_CONTROL |=> s_q.control == $past(req.wdata[4:0]))
    else $error("control write lost");
  plen_write_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    wr && req.addr == WDCT_OFF_PLEN |=> s_q.plen == $past(req.wdata[7:0]))
    else $error("pulse length write lost");
  count_ro_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    wr && req.addr == WDCT_OFF_COUNT && !s_q.control[WDCT_BIT_ENABLE]
      |=> $stable(s_q.count))
    else $error("count register was written");
  count_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    req.sel && !req.write && req.addr == WDCT_OFF_COUNT
      |=> reg_rdata == $past(s_q.count))
    else $error("count read wrong");
  status_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    req.sel && !req.write && req.addr == WDCT_OFF_STATUS
      |=> reg_rdata == {31'h00000000, $past(s_q.flag)})
    else $error("status read wrong");
  flag_ro_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    wr && req.addr == WDCT_OFF_STATUS && !reach |=> s_q.flag == $past(s_q.flag))
    else $error("status flag was written");
  restart_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    req.sel && !req.write && req.addr == WDCT_OFF_RESTART |=> reg_rdata == 32'h00000000)
    else $error("restart register not zero");
  revision_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
    req.sel && !req.write && req.addr == WDCT_OFF_REVISION |=> reg_rdata == REVISION)
    else $error("revision read wrong");

  // ----------------------------------------------------------------
  // Counter checks
  // ----------------------------------------------------------------
  // In external mode the count may only move on a synchronised rising edge.
  ext_tick_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    s_q.control[WDCT_BIT_CLK_SEL] && !tick && !wr |=> $stable(s_q.count))
    else $error("count moved without external edge");
  bad_key_live_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    wr && req.addr == WDCT_OFF_RESTART && req.wdata[15:0] != WDCT_RESTART_KEY
      && s_q.control[WDCT_BIT_ENABLE] && !s_q.control[WDCT_BIT_CLK_SEL]
      && s_q.count != 32'h00000000 |=> s_q.count == $past(s_q.count) - 32'h00000001)
    else $error("bad key disturbed counting");
  zero_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    s_q.count == 32'h00000000 && !wr |=> s_q.count == 32'h00000000)
    else $error("count left zero by itself");
  flag_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    s_q.flag && !(wr && req.addr == WDCT_OFF_CLEAR) |=> s_q.flag)
    else $error("flag dropped without clear");

  // ----------------------------------------------------------------
  // Pulse checks
  // ----------------------------------------------------------------
  pulse_start_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    !active && !reach |=> !active)
    else $error("pulse without reaching zero");
  pcnt_load_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    reach && !active |=> s_q.pcnt == $past(s_q.plen))
    else $error("pulse counter not loaded");
  pen_stable_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    active && s_q.pcnt != 8'h00 |=> active && $stable(s_q.pen))
    else $error("pulse cut short or enables moved");
  rst_off_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
    reach && !active && !s_q.control[WDCT_BIT_RST_EN] |=> !system_reset_pulse)
    else $error("reset pulse while disabled");
  irq_off_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
    reach && !active && !s_q.control[WDCT_BIT_IRQ_EN] |=> !system_irq_pulse)
    else $error("irq pulse while disabled");
  ext_off_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
    reach && !active && !s_q.control[WDCT_BIT_EXT_EN] |=> !external_device_pulse)
    else $error("external pulse while disabled");

  pulse_seen_c:  cover property (@(posedge clk) $rose(system_reset_pulse));
  reload_seen_c: cover property (@(posedge clk) wr && req.addr == WDCT_OFF_RESTART
    && req.wdata[15:0] == WDCT_RESTART_KEY);
  ext_tick_c:    cover property (@(posedge clk) s_q.control[WDCT_BIT_CLK_SEL] && tick);
  flag_clear_c:  cover property (@(posedge clk) s_q.flag && wr && req.addr == WDCT_OFF_CLEAR);
  quiet_reach_c: cover property (@(posedge clk) reach && !s_q.control[WDCT_BIT_RST_EN]);

endmodule // wdct_top

/* test/wdct_far_model.sv */
// Far-end model: slow external count clock source for the watchdog.
`timescale 1ns/1ps

module wdct_far_model (
  input  wire logic clk,
  input  wire logic run,
  output logic      external_count_clock
);
  logic [1:0] div_q;

  initial begin
    div_q = 2'h0;
    external_count_clock = 1'b0;
  end

  // external tick source
  // The clock stands low while idle so that no stray edge reaches the counter.
  always @(negedge clk) begin
    div_q <= div_q + 2'h1;
    if (!run) begin
      external_count_clock <= 1'b0;
    end else if (div_q == 2'h3) begin
      external_count_clock <= ~external_count_clock;
    end
  end
endmodule // wdct_far_model

/* test/test_watchdog_countdown_timer.sv */
// Self-checking bench for the watchdog countdown timer.
`timescale 1ns/1ps

module test_watchdog_countdown_timer;
  import wdct_pkg::*;
  localparam logic [31:0] REV = 32'h0000A5C3;  // Arbitrary revision code.
  logic        clk, sys_rst, reg_sel, reg_write, run;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_q, c1_q;
  logic        ext_clk, rst_p, irq_p, ext_p, st_p;
  int          err_count, check_count;

  wdct_top #(.REVISION(REV)) wdct_top_i (.clk(clk), .sys_rst(sys_rst), .reg_sel(reg_sel),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .external_count_clock(ext_clk), .system_reset_pulse(rst_p), .system_irq_pulse(irq_p),
    .external_device_pulse(ext_p), .status_pulse(st_p));
  wdct_far_model wdct_far_model_i (.clk(clk), .run(run), .external_count_clock(ext_clk));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_sel = 1'b1;
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_sel = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_sel = 1'b1;
    reg_write = 1'b0;
    reg_addr = a;
    @(negedge clk);
    rd_q = reg_rdata;
    reg_sel = 1'b0;
  endtask

  task automatic reset_values();
    logic [7:0]  adr [9];
    logic [31:0] exv [9];
    adr = '{WDCT_OFF_COUNT, WDCT_OFF_RELOAD, WDCT_OFF_RESTART, WDCT_OFF_CONTROL,
            WDCT_OFF_STATUS, WDCT_OFF_CLEAR, WDCT_OFF_PLEN, WDCT_OFF_REVISION, 8'h40};
    exv = '{WDCT_RST_COUNT, WDCT_RST_RELOAD, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFF, REV, 32'h0};
    for (int i = 0; i < 9; i++) begin
      rd(adr[i]);
      check(rd_q, exv[i]);
    end
  endtask

  task automatic read_only_and_key();
    wr(WDCT_OFF_COUNT, 32'h00001234);
    wr(WDCT_OFF_REVISION, 32'h0);
    rd(WDCT_OFF_COUNT);
    check(rd_q, WDCT_RST_COUNT);
    rd(WDCT_OFF_REVISION);
    check(rd_q, REV);
    wr(WDCT_OFF_STATUS, 32'h00000001);
    rd(WDCT_OFF_STATUS);
    check(rd_q, 32'h0);
    wr(WDCT_OFF_RELOAD, 32'h00000200);
    wr(WDCT_OFF_RESTART, 32'h00001234);
    rd(WDCT_OFF_COUNT);
    check(rd_q, WDCT_RST_COUNT);
    wr(WDCT_OFF_RESTART, {16'h0, WDCT_RESTART_KEY});
    rd(WDCT_OFF_COUNT);
    check(rd_q, 32'h00000200);
    rd(WDCT_OFF_RESTART);
    check(rd_q, 32'h0);
  endtask

  task automatic bus_clock_count();
    wr(WDCT_OFF_CONTROL, 32'h1);
    rd(WDCT_OFF_COUNT);
    c1_q = rd_q;
    // The two reads sample the count ten edges apart; the bad key between them must not reload.
    wr(WDCT_OFF_RESTART, 32'h00001234);
    repeat (6) @(negedge clk);
    rd(WDCT_OFF_COUNT);
    check(c1_q - rd_q, 32'd10);
    wr(WDCT_OFF_CONTROL, 32'h0);
    rd(WDCT_OFF_COUNT);
    c1_q = rd_q;
    repeat (20) @(negedge clk);
    rd(WDCT_OFF_COUNT);
    check(rd_q, c1_q);
  endtask

  task automatic ext_clock_count();
    wr(WDCT_OFF_RELOAD, 32'h00000040);
    wr(WDCT_OFF_RESTART, {16'h0, WDCT_RESTART_KEY});
    wr(WDCT_OFF_CONTROL, 32'h11);
    run = 1'b1;
    repeat (160) @(negedge clk);
    run = 1'b0;
    repeat (10) @(negedge clk);
    rd(WDCT_OFF_COUNT);
    check(32'(rd_q >= 32'h2A && rd_q <= 32'h2E), 32'h1);
    wr(WDCT_OFF_CONTROL, 32'h0);
  endtask

  task automatic keep_alive();
    wr(WDCT_OFF_RELOAD, 32'h00000020);
    wr(WDCT_OFF_RESTART, {16'h0, WDCT_RESTART_KEY});
    wr(WDCT_OFF_CONTROL, 32'h0F);
    for (int i = 0; i < 4; i++) begin
      repeat (10) @(negedge clk);
      wr(WDCT_OFF_RESTART, {16'h0, WDCT_RESTART_KEY});
      check({31'h0, st_p}, 32'h0);
    end
    rd(WDCT_OFF_STATUS);
    check(rd_q, 32'h0);
    wr(WDCT_OFF_CONTROL, 32'h0);
  endtask

  task automatic zero_reach();
    logic [4:0] ctl [5];
    logic [2:0] seen;
    int n;
    ctl = '{5'h0F, 5'h03, 5'h05, 5'h09, 5'h01};
    wr(WDCT_OFF_RELOAD, 32'h00000005);
    wr(WDCT_OFF_PLEN, 32'h00000003);
    for (int i = 0; i < 5; i++) begin
      wr(WDCT_OFF_RESTART, {16'h0, WDCT_RESTART_KEY});
      wr(WDCT_OFF_CONTROL, {27'h0, ctl[i]});
      n = 0;
      while (st_p !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      n = 0;
      seen = 3'h0;
      while (st_p === 1'b1 && n < 600) begin
        seen = seen | {rst_p, irq_p, ext_p};
        n++;
        @(negedge clk);
      end
      check(32'(n), 32'd4);
      check({29'h0, seen}, {29'h0, ctl[i][1], ctl[i][2], ctl[i][3]});
      repeat (20) @(negedge clk);
      check({31'h0, st_p}, 32'h0);
      rd(WDCT_OFF_STATUS);
      check(rd_q, 32'h1);
      wr(WDCT_OFF_CLEAR, {31'h0, i[0]});
      rd(WDCT_OFF_STATUS);
      check(rd_q, 32'h0);
      wr(WDCT_OFF_CONTROL, 32'h0);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    {sys_rst, reg_sel, reg_write, run} = 4'h8;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    err_count = 0;
    check_count = 0;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    reset_values();
    read_only_and_key();
    bus_clock_count();
    ext_clock_count();
    keep_alive();
    zero_reach();
    tally_and_finish();
  end
endmodule // test_watchdog_countdown_timer
